// file: pkg/rpd_defines.svh
// Constants for the reset and power-down controller.
`ifndef RPD_DEFINES_SVH
`define RPD_DEFINES_SVH

`define RPD_NPORTS      4
`define RPD_NGPIO       8
`define RPD_FM_W        6
`define RPD_CFG_W       25

// Reset values of the held control bits.
`define RPD_CHIP_RST_RST 1'b0
`define RPD_CHIP_DP_RST  1'b1
`define RPD_PORT_RST_RST 4'h0
`define RPD_PORT_DP_RST  4'hf
`define RPD_PORT_PD_RST  4'hf
`define RPD_FIFO_HLD_RST 4'hf

// Line mode code for a port whose line coder is in use.
`define RPD_LM_CODED     1'b1
// Framer mode code for clear channel, framer unused (arbitrary value).
`define RPD_FM_CLEAR     6'h3f
// Framer mode code for DS3 C-bit framing (arbitrary value).
`define RPD_FM_DS3_CBIT  6'h00

// Field positions of the default configuration word.
`define CFG_CLR_ON_WR    0
`define CFG_ADAPTER_EN   1
`define CFG_TIMERS_EN    2
`define CFG_LINE_B3ZS    3
`define CFG_TX_LINE_EN   4
`define CFG_FM_LSB       5
`define CFG_AUTO_AIS     11
`define CFG_AUTO_RDI     12
`define CFG_AUTO_FEBE    13
`define CFG_TXCLK_PIN    14
`define CFG_CELL_EN      15
`define CFG_SCRAMBLE     16
`define CFG_HEC_RECALC   17
`define CFG_COSET        18
`define CFG_UTOPIA_L2    19
`define CFG_BUS_W_LSB    20
`define CFG_ODD_PARITY   22
`define CFG_HEC_XFER     23
`define CFG_PIN_INVERT   24
`define CFG_BUS_8BIT     2'h0

`endif

// file: pkg/rpd_pkg.sv
// Types for the reset and power-down controller.
`default_nettype none
`include "rpd_defines.svh"
package rpd_pkg;

  // Complete state of the controller.
  typedef struct packed {
    logic                    sync1;
    logic                    sync2;
    logic                    chip_rst_bit;
    logic                    chip_dp_bit;
    logic [`RPD_NPORTS-1:0]  port_rst_bit;
    logic [`RPD_NPORTS-1:0]  port_dp_bit;
    logic [`RPD_NPORTS-1:0]  port_pd_bit;
    logic [`RPD_NPORTS-1:0]  fifo_hold;
    logic [`RPD_CFG_W-1:0]   cfg;
  } rpd_state_t;

endpackage

`default_nettype wire

// file: src/reset_powerdown_control.sv
// Chip and per-port reset, data-path reset and power-down controller.
//
// Operation
// [RL1] Chip reset from pin or sticky soft bit.
// [RL2] Port reset from chip reset or port bit.
// [RL3] Data-path reset forces transmit line outputs low.
// [RL4] Data-path and power-down outputs follow their bits.
// [RL5] Port power-down also forces port data-path reset.
// [RL6] Resets assert asynchronously, release on clock.
// [RL7] Power-down stops the affected port clocks.
// [RL8] System interface clocks are never stopped.
// [RL9] Reference timers and adapter off when disabled.
// [RL10] Chip reset reloads all defaults and flops.
// [RL11] Chip reset sets data-path and power-down bits.
// [RL12] Software: power up, configure, then release.
// [RL13] Software may release first, then configure.
// [RL14] General-purpose pins are inputs during reset.
// [RL15] Port outputs low until bits cleared.
// [RL16] System tri-states off, address outputs low.
// [RL17] Processor bus floats only for pin reset.
// [RL18] Defaults: clear-on-write, adapter and timers off.
// [RL19] Defaults: B3ZS, line off, C-bit, auto alarms.
// [RL20] Defaults: clock from adapter pin, cell features.
// [RL21] Cell FIFOs held in reset after reset.
// [RL22] Defaults: 8-bit level 2, odd parity.
// [RL23] Unused blocks held by line and framer mode.
`timescale 1ns/1ps
`default_nettype none
`include "rpd_defines.svh"

module reset_powerdown_control
  import rpd_pkg::*;
(
  input  wire logic                      REF_CLK,
  input  wire logic                      NRST,
  input  wire logic                      CHIP_CTRL_WE,
  input  wire logic                      CHIP_RST_WDATA,
  input  wire logic                      CHIP_DP_WDATA,
  input  wire logic [`RPD_NPORTS-1:0]    PORT_CTRL_WE,
  input  wire logic [`RPD_NPORTS-1:0]    PORT_RST_WDATA,
  input  wire logic [`RPD_NPORTS-1:0]    PORT_DP_WDATA,
  input  wire logic [`RPD_NPORTS-1:0]    PORT_PD_WDATA,
  input  wire logic [`RPD_NPORTS-1:0]    FIFO_HOLD_WE,
  input  wire logic [`RPD_NPORTS-1:0]    FIFO_HOLD_WDATA,
  input  wire logic                      REF8K_EXT_SEL,
  input  wire logic [2:0]                REF8K_SRC_SEL,
  input  wire logic [1:0]                ADAPTER_MODE_HI,
  input  wire logic [`RPD_NPORTS-1:0]    LINE_MODE,
  input  wire logic [4*`RPD_FM_W-1:0]    FRAMER_MODE,
  input  wire logic [`RPD_NGPIO-1:0]     GPIO_OE_REQ,
  output logic                           CHIP_RESET,
  output logic                           CHIP_DP_RESET,
  output logic [`RPD_NPORTS-1:0]         PORT_RESET,
  output logic [`RPD_NPORTS-1:0]         PORT_DP_RESET,
  output logic [`RPD_NPORTS-1:0]         PORT_POWER_DOWN,
  output logic                           CHIP_RST_BIT,
  output logic                           CHIP_DP_BIT,
  output logic [`RPD_NPORTS-1:0]         PORT_RST_BIT,
  output logic [`RPD_NPORTS-1:0]         PORT_DP_BIT,
  output logic [`RPD_NPORTS-1:0]         PORT_PD_BIT,
  output logic [`RPD_NPORTS-1:0]         PORT_CLK_EN,
  output logic                           SYS_CLK_EN,
  output logic                           REF8K_CLK_EN,
  output logic                           ADAPTER_CLK_EN,
  output logic [`RPD_NPORTS-1:0]         LINE_OUT_FORCE_LOW,
  output logic [`RPD_NPORTS-1:0]         FIFO_HOLD,
  output logic [2*`RPD_NPORTS-1:0]       BLOCK_HOLD,
  output logic [`RPD_NGPIO-1:0]          GPIO_OE,
  output logic                           SYS_TRISTATE_HIZ,
  output logic                           SYS_ADDR_FORCE_LOW,
  output logic                           PROC_BUS_HIZ,
  output logic [`RPD_CFG_W-1:0]          CFG_DEFAULT,
  output logic [`RPD_NPORTS-1:0]         CFG_LOAD
);

  ////////////////////////////////////////////////////////////////////////////
  // Constants and decoding

  // Default configuration word that every reset reloads.
  localparam logic [`RPD_CFG_W-1:0] CFG_RESET_VALUE =
      (`RPD_CFG_W'(1) << `CFG_CLR_ON_WR)
    | (`RPD_CFG_W'(0) << `CFG_ADAPTER_EN)
    | (`RPD_CFG_W'(0) << `CFG_TIMERS_EN)
    | (`RPD_CFG_W'(1) << `CFG_LINE_B3ZS)
    | (`RPD_CFG_W'(0) << `CFG_TX_LINE_EN)
    | (`RPD_CFG_W'(`RPD_FM_DS3_CBIT) << `CFG_FM_LSB)
    | (`RPD_CFG_W'(1) << `CFG_AUTO_AIS)
    | (`RPD_CFG_W'(1) << `CFG_AUTO_RDI)
    | (`RPD_CFG_W'(1) << `CFG_AUTO_FEBE)
    | (`RPD_CFG_W'(1) << `CFG_TXCLK_PIN)
    | (`RPD_CFG_W'(1) << `CFG_CELL_EN)
    | (`RPD_CFG_W'(1) << `CFG_SCRAMBLE)
    | (`RPD_CFG_W'(1) << `CFG_HEC_RECALC)
    | (`RPD_CFG_W'(1) << `CFG_COSET)
    | (`RPD_CFG_W'(1) << `CFG_UTOPIA_L2)
    | (`RPD_CFG_W'(`CFG_BUS_8BIT) << `CFG_BUS_W_LSB)
    | (`RPD_CFG_W'(1) << `CFG_ODD_PARITY)
    | (`RPD_CFG_W'(0) << `CFG_HEC_XFER)
    | (`RPD_CFG_W'(0) << `CFG_PIN_INVERT);

  // Reset image of the whole state; only constants reach the flops.
  localparam rpd_state_t STATE_RESET = '{
    sync1:        1'b0,
    sync2:        1'b0,
    chip_rst_bit: `RPD_CHIP_RST_RST,
    chip_dp_bit:  `RPD_CHIP_DP_RST,
    port_rst_bit: `RPD_PORT_RST_RST,
    port_dp_bit:  `RPD_PORT_DP_RST,
    port_pd_bit:  `RPD_PORT_PD_RST,
    fifo_hold:    `RPD_FIFO_HLD_RST,
    cfg:          CFG_RESET_VALUE
  };

  // Hold mask for one port: bit 0 line coder, bit 1 framer.
  function automatic logic [1:0] unused_blocks(input logic lm,
                                               input logic [`RPD_FM_W-1:0] fm);
    unused_blocks[0] = (lm != `RPD_LM_CODED);
    unused_blocks[1] = (fm == `RPD_FM_CLEAR);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  rpd_state_t s_reg;
  rpd_state_t s_next;
  logic       pin_active;
  logic       chip_reset;
  logic [`RPD_NPORTS-1:0] port_reset;

  // The pin enters through a reset synchronizer: assertion clears the
  // flops at once, release needs two clock edges so nothing leaves reset
  // on a runt edge.
  assign pin_active = ~s_reg.sync2;                     // [RL6]
  assign chip_reset = pin_active | s_reg.chip_rst_bit;  // [RL1]
  assign port_reset = {`RPD_NPORTS{chip_reset}} | s_reg.port_rst_bit;  // [RL2]

  // Next state of every held bit, forced values taking priority over writes.
  always_comb begin
    s_next       = s_reg;
    s_next.sync1 = 1'b1;                               // [RL6]
    s_next.sync2 = s_reg.sync1;
    // The soft bit clears itself while the pin is held.
    if (pin_active) begin
      s_next.chip_rst_bit = 1'b0;                      // [RL1]
    end else if (CHIP_CTRL_WE) begin
      s_next.chip_rst_bit = CHIP_RST_WDATA;            // [RL1]
    end
    if (chip_reset) begin
      s_next.chip_dp_bit = 1'b1;                       // [RL11]
      s_next.cfg         = CFG_RESET_VALUE;            // [RL10]
    end else if (CHIP_CTRL_WE) begin
      s_next.chip_dp_bit = CHIP_DP_WDATA;
    end
    for (int i = 0; i < `RPD_NPORTS; i++) begin
      if (chip_reset) begin
        s_next.port_rst_bit[i] = 1'b0;                 // [RL2]
      end else if (PORT_CTRL_WE[i]) begin
        s_next.port_rst_bit[i] = PORT_RST_WDATA[i];
      end
      // A clear only sticks once neither reset holds the port.
      if (port_reset[i]) begin
        s_next.port_dp_bit[i] = 1'b1;                  // [RL11]
        s_next.port_pd_bit[i] = 1'b1;                  // [RL11]
      end else if (PORT_CTRL_WE[i]) begin
        s_next.port_dp_bit[i] = PORT_DP_WDATA[i];
        s_next.port_pd_bit[i] = PORT_PD_WDATA[i];
      end
      // Cell FIFOs stay held until software lets them go.
      if (port_reset[i]) begin
        s_next.fifo_hold[i] = 1'b1;                    // [RL21]
      end else if (FIFO_HOLD_WE[i]) begin
        s_next.fifo_hold[i] = FIFO_HOLD_WDATA[i];
      end
    end
  end

  // One register for the whole state, cleared straight from the pin.
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      s_reg <= STATE_RESET;                            // [RL6]
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Forced terms are ORed in so every reset reaches its output at once.
  assign CHIP_RESET      = chip_reset;                                 // [RL1]
  assign PORT_RESET      = port_reset;                                 // [RL2]
  assign CHIP_DP_RESET   = s_reg.chip_dp_bit | chip_reset;             // [RL4]
  assign PORT_POWER_DOWN = s_reg.port_pd_bit | port_reset;             // [RL4]
  assign PORT_DP_RESET   = {`RPD_NPORTS{CHIP_DP_RESET}} | s_reg.port_dp_bit
                         | PORT_POWER_DOWN | port_reset;               // [RL4] [RL5]
  assign CHIP_RST_BIT    = s_reg.chip_rst_bit;
  assign CHIP_DP_BIT     = s_reg.chip_dp_bit;
  assign PORT_RST_BIT    = s_reg.port_rst_bit;
  assign PORT_DP_BIT     = s_reg.port_dp_bit;
  assign PORT_PD_BIT     = s_reg.port_pd_bit;

  // Clock gating enables; the gating cells themselves sit with the clock tree.
  // Data-path reset leaves clocks running so the adapter PLLs can settle.
  assign PORT_CLK_EN    = ~PORT_POWER_DOWN;                            // [RL7]
  assign SYS_CLK_EN     = 1'b1;                                        // [RL8]
  assign REF8K_CLK_EN   = REF8K_EXT_SEL | (REF8K_SRC_SEL != 3'h0);     // [RL9]
  assign ADAPTER_CLK_EN = (ADAPTER_MODE_HI != 2'h0);                   // [RL9]

  // Line and overhead outputs sit low through reset, data-path reset and
  // power-down; a port is only released once both of its bits are clear.
  assign LINE_OUT_FORCE_LOW = PORT_DP_RESET;                           // [RL3] [RL15]
  assign FIFO_HOLD          = s_reg.fifo_hold;                         // [RL21]

  // Per-port hold of blocks that the chosen modes leave idle.
  for (genvar g = 0; g < `RPD_NPORTS; g++) begin : g_block
    assign BLOCK_HOLD[2*g +: 2] = unused_blocks(LINE_MODE[g],
                                    FRAMER_MODE[g*`RPD_FM_W +: `RPD_FM_W])
                                | {2{PORT_POWER_DOWN[g]}};             // [RL23]
  end

  // Pin states during reset.
  assign GPIO_OE            = chip_reset ? '0 : GPIO_OE_REQ;           // [RL14]
  assign SYS_TRISTATE_HIZ   = chip_reset;                              // [RL16]
  assign SYS_ADDR_FORCE_LOW = chip_reset;                              // [RL16]
  // The soft bit must not float the bus that software uses to clear it.
  assign PROC_BUS_HIZ       = pin_active;                              // [RL17]

  // Default configuration for the port and chip registers.
  assign CFG_DEFAULT = s_reg.cfg;                                      // [RL18] [RL19] [RL20] [RL22]
  assign CFG_LOAD    = port_reset;                                     // [RL10]

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence s_soft_rst_write;
    CHIP_CTRL_WE && CHIP_RST_WDATA && !pin_active;
  endsequence

  sequence s_port_release;
    PORT_RESET[0] ##1 !PORT_RESET[0];
  endsequence

  property p_soft_reset_sets;
    @(posedge REF_CLK) disable iff (!NRST)
      s_soft_rst_write |=> CHIP_RESET && CHIP_RST_BIT;
  endproperty
  a_soft_reset_sets: assert property (p_soft_reset_sets)  // [RL1]
    else $error("chip soft reset write did not raise chip reset");

  property p_soft_reset_sticks;
    @(posedge REF_CLK) disable iff (!NRST)
      CHIP_RST_BIT && !CHIP_CTRL_WE |=> CHIP_RST_BIT;
  endproperty
  a_soft_reset_sticks: assert property (p_soft_reset_sticks)  // [RL1]
    else $error("chip soft reset bit dropped without a write");

  property p_port_follows_chip;
    @(posedge REF_CLK) disable iff (!NRST)
      CHIP_RESET |-> (&PORT_RESET) ##1 (PORT_RST_BIT == '0);
  endproperty
  a_port_follows_chip: assert property (p_port_follows_chip)  // [RL2]
    else $error("port reset not asserted or port bit kept under chip reset");

  property p_dp_combines;
    @(posedge REF_CLK) disable iff (!NRST)
      PORT_DP_RESET == ({`RPD_NPORTS{CHIP_DP_RESET}} | PORT_DP_BIT
                        | PORT_POWER_DOWN);
  endproperty
  a_dp_combines: assert property (p_dp_combines)  // [RL4]
    else $error("port data-path reset does not match its sources");

  property p_pd_forces_dp;
    @(posedge REF_CLK) disable iff (!NRST)
      (PORT_POWER_DOWN & ~PORT_DP_RESET) == '0;
  endproperty
  a_pd_forces_dp: assert property (p_pd_forces_dp)  // [RL5]
    else $error("powered-down port left out of data-path reset");

  property p_reset_sets_bits;
    @(posedge REF_CLK) disable iff (!NRST)
      CHIP_RESET |=> CHIP_DP_BIT && (&PORT_DP_BIT) && (&PORT_PD_BIT)
                     && (&FIFO_HOLD) && (CFG_DEFAULT == CFG_RESET_VALUE);
  endproperty
  a_reset_sets_bits: assert property (p_reset_sets_bits)  // [RL11]
    else $error("chip reset did not set data-path and power-down bits");

  property p_pd_clock_off;
    @(posedge REF_CLK) disable iff (!NRST)
      PORT_CTRL_WE[0] && PORT_PD_WDATA[0] |=> !PORT_CLK_EN[0] && SYS_CLK_EN;
  endproperty
  a_pd_clock_off: assert property (p_pd_clock_off)  // [RL7]
    else $error("port clock still enabled after power-down");

  property p_gpio_inputs;
    @(posedge REF_CLK) disable iff (!NRST)
      CHIP_RESET |-> GPIO_OE == '0 && SYS_TRISTATE_HIZ && SYS_ADDR_FORCE_LOW;
  endproperty
  a_gpio_inputs: assert property (p_gpio_inputs)  // [RL14]
    else $error("pins not in reset state during chip reset");

  property p_line_low;
    @(posedge REF_CLK) disable iff (!NRST)
      (PORT_PD_BIT[0] || PORT_DP_BIT[0] || PORT_RESET[0]) |-> LINE_OUT_FORCE_LOW[0];
  endproperty
  a_line_low: assert property (p_line_low)  // [RL15]
    else $error("port outputs released while port still held");

  property p_bus_float_pin_only;
    @(posedge REF_CLK) disable iff (!NRST)
      s_soft_rst_write |=> !PROC_BUS_HIZ [*2];
  endproperty
  a_bus_float_pin_only: assert property (p_bus_float_pin_only)  // [RL17]
    else $error("processor bus floated for a soft reset");

  property p_fifo_held;
    @(posedge REF_CLK) disable iff (!NRST)
      s_port_release |-> FIFO_HOLD[0];
  endproperty
  a_fifo_held: assert property (p_fifo_held)  // [RL21]
    else $error("cell FIFO not held when port reset ended");

  // Checked cycle by cycle so that the hold needs no open-ended window.
  property p_fifo_sticky;
    @(posedge REF_CLK) disable iff (!NRST)
      FIFO_HOLD[0] && !FIFO_HOLD_WE[0] |=> FIFO_HOLD[0];
  endproperty
  a_fifo_sticky: assert property (p_fifo_sticky)  // [RL21]
    else $error("cell FIFO released without a software write");

  property p_chip_dp_release;
    @(posedge REF_CLK) disable iff (!NRST)
      CHIP_CTRL_WE && !CHIP_RST_WDATA && !CHIP_DP_WDATA && !CHIP_RESET |=> !CHIP_DP_RESET;
  endproperty
  a_chip_dp_release: assert property (p_chip_dp_release)  // [RL4]
    else $error("chip data-path reset stayed on after its bit was cleared");

  property p_ref8k_off;
    @(posedge REF_CLK) disable iff (!NRST)
      !REF8K_EXT_SEL && REF8K_SRC_SEL == 3'h0 |-> !REF8K_CLK_EN;
  endproperty
  a_ref8k_off: assert property (p_ref8k_off)  // [RL9]
    else $error("reference timer clock running with no source selected");

  property p_adapter_off;
    @(posedge REF_CLK) disable iff (!NRST)
      ADAPTER_MODE_HI == 2'h0 |-> !ADAPTER_CLK_EN;
  endproperty
  a_adapter_off: assert property (p_adapter_off)  // [RL9]
    else $error("adapter clock running while the adapter is disabled");

  property p_pd_holds_blocks;
    @(posedge REF_CLK) disable iff (!NRST)
      PORT_POWER_DOWN[0] |-> BLOCK_HOLD[1:0] == 2'h3;
  endproperty
  a_pd_holds_blocks: assert property (p_pd_holds_blocks)  // [RL23]
    else $error("powered-down port left a block out of hold");

endmodule // reset_powerdown_control

`default_nettype wire

// file: tb/reset_powerdown_control_tb.sv
// Self-checking testbench for the reset and power-down controller.
`timescale 1ns/1ps
`default_nettype none
`include "rpd_defines.svh"

module reset_powerdown_control_tb;

  logic        ref_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        cwe = 1'b0;
  logic        crst_d = 1'b0;
  logic        cdp_d = 1'b0;
  logic [3:0]  pwe = 4'h0;
  logic [3:0]  prst_d = 4'h0;
  logic [3:0]  pdp_d = 4'h0;
  logic [3:0]  ppd_d = 4'h0;
  logic [3:0]  fwe = 4'h0;
  logic [3:0]  fd = 4'h0;
  logic        x8sel = 1'b0;
  logic [2:0]  x8src = 3'h0;
  logic [1:0]  amode = 2'h0;
  logic [3:0]  lmode = 4'h0;
  logic [23:0] fmode = 24'h0;
  logic [7:0]  gpreq = 8'ha5;
  logic        chip_reset, chip_dp_reset, chip_rst_bit, chip_dp_bit, sys_clk_en;
  logic        ref8k_clk_en, adapter_clk_en, sys_tristate_hiz, sys_addr_force_low, proc_bus_hiz;
  logic [3:0]  port_reset, port_dp_reset, port_power_down, port_rst_bit, port_dp_bit;
  logic [3:0]  port_pd_bit, port_clk_en, line_out_force_low, fifo_hold, cfg_load;
  logic [7:0]  block_hold, gpio_oe;
  logic [24:0] cfg_default, exp_cfg;
  int          num_errors = 0;
  int          tests_run = 0;
  int          cycles = 0;

  reset_powerdown_control reset_powerdown_control_inst (
    .REF_CLK(ref_clk), .NRST(nrst), .CHIP_CTRL_WE(cwe), .CHIP_RST_WDATA(crst_d),
    .CHIP_DP_WDATA(cdp_d), .PORT_CTRL_WE(pwe), .PORT_RST_WDATA(prst_d), .PORT_DP_WDATA(pdp_d),
    .PORT_PD_WDATA(ppd_d), .FIFO_HOLD_WE(fwe), .FIFO_HOLD_WDATA(fd), .REF8K_EXT_SEL(x8sel),
    .REF8K_SRC_SEL(x8src), .ADAPTER_MODE_HI(amode), .LINE_MODE(lmode), .FRAMER_MODE(fmode),
    .GPIO_OE_REQ(gpreq), .CHIP_RESET(chip_reset), .CHIP_DP_RESET(chip_dp_reset),
    .PORT_RESET(port_reset), .PORT_DP_RESET(port_dp_reset), .PORT_POWER_DOWN(port_power_down),
    .CHIP_RST_BIT(chip_rst_bit), .CHIP_DP_BIT(chip_dp_bit), .PORT_RST_BIT(port_rst_bit),
    .PORT_DP_BIT(port_dp_bit), .PORT_PD_BIT(port_pd_bit), .PORT_CLK_EN(port_clk_en),
    .SYS_CLK_EN(sys_clk_en), .REF8K_CLK_EN(ref8k_clk_en), .ADAPTER_CLK_EN(adapter_clk_en),
    .LINE_OUT_FORCE_LOW(line_out_force_low), .FIFO_HOLD(fifo_hold), .BLOCK_HOLD(block_hold),
    .GPIO_OE(gpio_oe), .SYS_TRISTATE_HIZ(sys_tristate_hiz),
    .SYS_ADDR_FORCE_LOW(sys_addr_force_low), .PROC_BUS_HIZ(proc_bus_hiz),
    .CFG_DEFAULT(cfg_default), .CFG_LOAD(cfg_load)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, hang guard and shared tasks.
  always #2 ref_clk = ~ref_clk;

  // The whole sequence needs well under 300 cycles, so 3000 only trips on a hang.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      results();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // Settle one edge, then look once its updates have landed.
  task automatic tick;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic chip_wr(input logic r, input logic d);
    @(posedge ref_clk);
    cwe <= 1'b1;
    crst_d <= r;
    cdp_d <= d;
    @(posedge ref_clk);
    cwe <= 1'b0;
    #1;
  endtask

  task automatic port_wr(input int i, input logic r, input logic d, input logic p);
    @(posedge ref_clk);
    pwe[i] <= 1'b1;
    prst_d[i] <= r;
    pdp_d[i] <= d;
    ppd_d[i] <= p;
    @(posedge ref_clk);
    pwe[i] <= 1'b0;
    #1;
  endtask

  task automatic fifo_wr(input int i, input logic v);
    @(posedge ref_clk);
    fwe[i] <= 1'b1;
    fd[i] <= v;
    @(posedge ref_clk);
    fwe[i] <= 1'b0;
    #1;
  endtask

  task automatic results;
    $display("Checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    exp_cfg = 25'h0;
    exp_cfg[`CFG_CLR_ON_WR] = 1'b1;
    exp_cfg[`CFG_LINE_B3ZS] = 1'b1;
    for (int b = `CFG_AUTO_AIS; b <= `CFG_UTOPIA_L2; b++) exp_cfg[b] = 1'b1;
    exp_cfg[`CFG_ODD_PARITY] = 1'b1;
    exp_cfg[`CFG_FM_LSB +: 6] = `RPD_FM_DS3_CBIT;
    // Pin reset held: every output sits in its safe state.
    repeat (2) @(posedge ref_clk);
    #1;
    check(chip_reset, 1);
    check(port_reset, 4'hf);
    check(proc_bus_hiz, 1);
    check(gpio_oe, 8'h00);
    check(port_clk_en, 4'h0);
    check(sys_clk_en, 1);
    check(line_out_force_low, 4'hf);
    check({sys_tristate_hiz, sys_addr_force_low}, 2'h3);
    check(fifo_hold, 4'hf);
    check(cfg_load, 4'hf);
    check(cfg_default, exp_cfg);
    @(posedge ref_clk);
    nrst <= 1'b1;
    tick();
    check(chip_reset, 1);
    tick();
    check(chip_reset, 0);
    check(proc_bus_hiz, 0);
    check(gpio_oe, gpreq);
    check({chip_dp_bit, port_dp_bit, port_pd_bit}, 9'h1ff);
    check(port_dp_reset, 4'hf);
    // Every mix of chip dp, port dp and power-down bits on port 0.
    for (int k = 0; k < 8; k++) begin
      chip_wr(1'b0, k[2]);
      port_wr(0, 1'b0, k[1], k[0]);
      check(chip_dp_reset, k[2]);
      check(port_dp_reset[0], k[2] | k[1] | k[0]);
      check(port_power_down[0], k[0]);
      check(port_clk_en[0], !k[0]);
      check(line_out_force_low[0], k[2] | k[1] | k[0]);
    end
    // Release everything first, then configure the cell FIFO below.
    chip_wr(1'b0, 1'b0);
    for (int i = 0; i < 4; i++) port_wr(i, 1'b0, 1'b0, 1'b0);
    check(port_clk_en, 4'hf);
    check(port_dp_reset, 4'h0);
    // Port soft reset on port 1 only, with its cell FIFO released first.
    fifo_wr(1, 1'b0);
    check(fifo_hold, 4'hd);
    port_wr(1, 1'b1, 1'b0, 1'b0);
    check(port_reset, 4'h2);
    check(cfg_load, 4'h2);
    check(line_out_force_low, 4'h2);
    check(chip_reset, 0);
    tick();
    check({port_dp_bit, port_pd_bit, fifo_hold}, 12'h22f);
    port_wr(1, 1'b0, 1'b0, 1'b0);
    check(port_reset, 4'h0);
    check(line_out_force_low, 4'h2);
    port_wr(1, 1'b0, 1'b0, 1'b0);
    check(line_out_force_low, 4'h0);
    // Chip soft reset: processor bus keeps driving, port write refused.
    chip_wr(1'b1, 1'b0);
    check(chip_reset, 1);
    check(proc_bus_hiz, 0);
    check(gpio_oe, 8'h00);
    check(sys_tristate_hiz, 1);
    check(cfg_default, exp_cfg);
    check(port_reset, 4'hf);
    port_wr(2, 1'b1, 1'b0, 1'b0);
    check(port_rst_bit, 4'h0);
    check({chip_dp_bit, port_dp_bit, port_pd_bit}, 9'h1ff);
    chip_wr(1'b0, 1'b0);
    check(chip_reset, 0);
    check(chip_rst_bit, 0);
    // Pin reset in mid-cycle clears the sticky soft bit without a clock edge.
    chip_wr(1'b1, 1'b0);
    @(posedge ref_clk);
    #1;
    nrst <= 1'b0;
    #1;
    check(chip_rst_bit, 0);
    check(proc_bus_hiz, 1);
    @(posedge ref_clk);
    nrst <= 1'b1;
    tick();
    tick();
    check(chip_reset, 0);
    // Recommended bring-up on port 0: power up, configure, then release.
    port_wr(0, 1'b0, 1'b1, 1'b0);
    check({port_power_down[0], port_clk_en[0], port_dp_reset[0]}, 3'h3);
    fifo_wr(0, 1'b0);
    check({fifo_hold[0], line_out_force_low[0]}, 2'h1);
    chip_wr(1'b0, 1'b0);
    check({chip_dp_reset, port_dp_reset[0]}, 2'h1);
    port_wr(0, 1'b0, 1'b0, 1'b0);
    check({port_dp_reset[0], line_out_force_low[0]}, 2'h0);
    // Reference and adapter clock enables over all source codes.
    for (int k = 0; k < 16; k++) begin
      @(posedge ref_clk);
      x8sel <= k[3];
      x8src <= k[2:0];
      amode <= k[1:0];
      #1;
      check(ref8k_clk_en, k[3] | (k[2:0] != 0));
      check(adapter_clk_en, k[1:0] != 0);
    end
    // Unused line coder and framer held idle on port 2.
    port_wr(2, 1'b0, 1'b0, 1'b0);
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk);
      lmode[2] <= k[0];
      fmode[17:12] <= k[1] ? `RPD_FM_CLEAR : `RPD_FM_DS3_CBIT;
      #1;
      check(block_hold[5:4], {k[1], !k[0]});
    end
    port_wr(2, 1'b0, 1'b0, 1'b1);
    check(block_hold[5:4], 2'h3);
    results();
  end

endmodule // reset_powerdown_control_tb

`default_nettype wire
